// ### rtl/smpac_glue.sv
// Access gating, shared RAM and pin routing of the dual serial module
// Overview of operation
// - Global registers reachable only in supervisor state
// - Restrict bit set makes assignable space supervisor-only
// - Restrict bit clear admits user and supervisor
// - Denied reads return zero, denied writes ignored
// - Restrict bit cleared only by supervisor access
// - Byte, word and long accesses everywhere
// - 80-byte RAM, spare bytes general storage
// - Queue uses separate receive, transmit, command regions
// - Sync open-drain bit governs seven sync pins
// - Async open-drain bit governs transmit pin
// - Receive pin is dedicated async input
// - Transmit pin general purpose unless transmitter enabled
// - Transmit direction bit ignored while async enabled
// - Chip-select zero pin doubles as slave select
// - Clock pin output master, input slave
// - MISO input master, output slave
// - MOSI output master, input slave
// - Master drives chip-selects as outputs, chip-select zero only with its direction bit set
// - Master samples slave select for mode fault
// - Unused sync pins except clock are general purpose
// - Eight non-receive pins usable as general purpose
`timescale 1ns/1ps
`default_nettype none
module smpac_glue (
  input  wire logic        CLK_I,
  input  wire logic        RSTN_I,
  input  wire logic        ACC_REQ_I,
  input  wire logic        ACC_WR_I,
  input  wire logic        ACC_SUPER_I,
  input  wire logic [1:0]  ACC_SIZE_I,
  input  wire logic [8:0]  ACC_ADDR_I,
  input  wire logic [31:0] ACC_WDATA_I,
  output logic             ACC_ACK_O,
  output logic             ACC_DENY_O,
  output logic [31:0]      ACC_RDATA_O,
  output logic             SUPERVISOR_RESTRICT_BIT_O,
  input  wire logic        SYNC_EN_I,
  input  wire logic        SYNC_MASTER_I,
  input  wire logic        SYNC_OPEN_DRAIN_I,
  input  wire logic        SYNC_MISO_I,
  input  wire logic        SYNC_MOSI_I,
  input  wire logic        SYNC_SCK_I,
  input  wire logic [3:0]  SYNC_PCS_I,
  output logic             SYNC_DIN_O,
  output logic             SYNC_SCK_O,
  output logic             SYNC_SEL_O,
  output logic             SYNC_MODE_FAULT_O,
  input  wire logic        SYNC_RAM_REQ_I,
  input  wire logic        SYNC_RAM_WR_I,
  input  wire logic [1:0]  SYNC_RAM_REGION_I,
  input  wire logic [4:0]  SYNC_RAM_IDX_I,
  input  wire logic [7:0]  SYNC_RAM_WDATA_I,
  output logic [7:0]       SYNC_RAM_RDATA_O,
  input  wire logic        ASYNC_TX_ENABLE_I,
  input  wire logic        ASYNC_OPEN_DRAIN_I,
  input  wire logic        ASYNC_TXD_I,
  output logic             ASYNC_RXD_O,
  input  wire logic        PIN_RXD_I,
  input  wire logic [7:0]  PIN_I,
  output logic [7:0]       PIN_O,
  output logic [7:0]       PIN_OE_O
);
  // ==========================================================
  // State
  localparam int unsigned RAM_BYTES = smpac_pkg::RAM_BYTES;
  logic        supervisor_restrict_bit_reg;
  logic [7:0]  pdata_reg;
  logic [7:0]  asgn_reg;
  logic [7:0]  dir_reg;
  logic [7:0]  ram_reg [RAM_BYTES];
  logic [7:0]  pin_s1_reg;
  logic [7:0]  pin_s2_reg;
  logic        rxd_s1_reg;
  logic        rxd_s2_reg;
  logic [2:0]  nbytes;
  logic        permit;
  logic [31:0] rdata_next;
  logic [6:0]  qaddr;
  logic [7:0]  ser;
  logic [7:0]  sdrv;
  logic [7:0]  sval;
  logic [7:0]  drv;
  logic [7:0]  val;
  logic [7:0]  od;
  logic        ss_act;

  // ==========================================================
  // Access decode
  function automatic logic in_ram(input logic [8:0] a);
    in_ram = (a >= smpac_pkg::RAM_OFS)
           && (a < smpac_pkg::RAM_OFS + 9'(RAM_BYTES));
  endfunction

  function automatic logic [7:0] rd_byte(input logic [8:0] a);
    logic [8:0] r;
    r = a - smpac_pkg::RAM_OFS;
    if (a == smpac_pkg::CFG_OFS + 9'h001)
      rd_byte = {supervisor_restrict_bit_reg, 7'h00};
    else if (a == smpac_pkg::PDATA_OFS + 9'h001)
      rd_byte = pin_s2_reg;
    else if (a == smpac_pkg::PASGN_OFS)
      rd_byte = asgn_reg;
    else if (a == smpac_pkg::PASGN_OFS + 9'h001)
      rd_byte = dir_reg;
    else if (in_ram(a))
      rd_byte = ram_reg[r[6:0]];
    else
      rd_byte = 8'h00;
  endfunction

  always_comb
  begin
    case (ACC_SIZE_I)
      smpac_pkg::SZ_BYTE: nbytes = 3'h1;
      smpac_pkg::SZ_WORD: nbytes = 3'h2;
      default:            nbytes = 3'h4;
    endcase
    // Global space always needs supervisor; restrict bit extends it
    permit = ACC_SUPER_I
           || (!supervisor_restrict_bit_reg && (ACC_ADDR_I >= smpac_pkg::GLOBAL_END));
    rdata_next = 32'h0;
    for (int k = 0; k < 4; k++)
    begin
      if (3'(k) < nbytes)
        rdata_next = {rdata_next[23:0], rd_byte(ACC_ADDR_I + 9'(k))};
    end
    if (!permit)
      rdata_next = 32'h0;
  end

  // ==========================================================
  // Answer to the processor, one cycle after the request
  always_ff @(posedge CLK_I)
  begin
    if (!RSTN_I)
    begin
      ACC_ACK_O   <= 1'b0;
      ACC_DENY_O  <= 1'b0;
      ACC_RDATA_O <= 32'h0;
    end
    else
    begin
      ACC_ACK_O   <= ACC_REQ_I;
      ACC_DENY_O  <= ACC_REQ_I && !permit;
      ACC_RDATA_O <= (ACC_REQ_I && !ACC_WR_I) ? rdata_next : 32'h0;
    end
  end

  // ==========================================================
  // Configuration and pin control registers
  // Write bytes are big-endian, right-justified in the data word
  always_ff @(posedge CLK_I)
  begin
    if (!RSTN_I)
    begin
      supervisor_restrict_bit_reg  <= smpac_pkg::SUPERVISOR_RESTRICT_BIT_RST;
      pdata_reg <= smpac_pkg::PIN_RST;
      asgn_reg  <= smpac_pkg::PIN_RST;
      dir_reg   <= smpac_pkg::PIN_RST;
    end
    else if (ACC_REQ_I && ACC_WR_I && permit)
    begin
      for (int k = 0; k < 4; k++)
      begin
        if (3'(k) < nbytes)
        begin
          if (ACC_ADDR_I + 9'(k) == smpac_pkg::CFG_OFS + 9'h001)
            supervisor_restrict_bit_reg <= ACC_WDATA_I[8*(int'(nbytes)-1-k) + smpac_pkg::SUPERVISOR_RESTRICT_BIT_POS];
          else if (ACC_ADDR_I + 9'(k) == smpac_pkg::PDATA_OFS + 9'h001)
            pdata_reg <= ACC_WDATA_I[8*(int'(nbytes)-1-k) +: 8];
          else if (ACC_ADDR_I + 9'(k) == smpac_pkg::PASGN_OFS)
            asgn_reg <= ACC_WDATA_I[8*(int'(nbytes)-1-k) +: 8]
                      & smpac_pkg::ASGN_MASK;
          else if (ACC_ADDR_I + 9'(k) == smpac_pkg::PASGN_OFS + 9'h001)
            dir_reg <= ACC_WDATA_I[8*(int'(nbytes)-1-k) +: 8];
        end
      end
    end
  end

  // ==========================================================
  // Shared RAM; the queue port wins a same-byte write collision
  always_comb
  begin
    case (SYNC_RAM_REGION_I)
      smpac_pkg::RG_RX:  qaddr = smpac_pkg::RX_BASE + {2'b00, SYNC_RAM_IDX_I};
      smpac_pkg::RG_TX:  qaddr = smpac_pkg::TX_BASE + {2'b00, SYNC_RAM_IDX_I};
      default:           qaddr = smpac_pkg::CMD_BASE + {3'b000, SYNC_RAM_IDX_I[3:0]};
    endcase
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RSTN_I)
    begin
      for (int i = 0; i < RAM_BYTES; i++)
        ram_reg[i] <= 8'h00;
    end
    else
    begin
      for (int k = 0; k < 4; k++)
      begin
        if (ACC_REQ_I && ACC_WR_I && permit && (3'(k) < nbytes)
            && in_ram(ACC_ADDR_I + 9'(k)))
          ram_reg[7'(ACC_ADDR_I + 9'(k) - smpac_pkg::RAM_OFS)]
            <= ACC_WDATA_I[8*(int'(nbytes)-1-k) +: 8];
      end
      if (SYNC_RAM_REQ_I && SYNC_RAM_WR_I && (qaddr < 7'(RAM_BYTES)))
        ram_reg[qaddr] <= SYNC_RAM_WDATA_I;
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RSTN_I)
      SYNC_RAM_RDATA_O <= 8'h00;
    else if (SYNC_RAM_REQ_I && !SYNC_RAM_WR_I)
      SYNC_RAM_RDATA_O <= (qaddr < 7'(RAM_BYTES)) ? ram_reg[qaddr] : 8'h00;
  end

  // ==========================================================
  // Pin synchronisers
  always_ff @(posedge CLK_I)
  begin
    if (!RSTN_I)
    begin
      pin_s1_reg <= 8'h00;
      pin_s2_reg <= 8'h00;
      rxd_s1_reg <= 1'b1;
      rxd_s2_reg <= 1'b1;
    end
    else
    begin
      pin_s1_reg <= PIN_I;
      pin_s2_reg <= pin_s1_reg;
      rxd_s1_reg <= PIN_RXD_I;
      rxd_s2_reg <= rxd_s1_reg;
    end
  end

  assign ASYNC_RXD_O = rxd_s2_reg;
  assign SUPERVISOR_RESTRICT_BIT_O      = supervisor_restrict_bit_reg;

  // ==========================================================
  // Pin routing
  always_comb
  begin
    ser  = {ASYNC_TX_ENABLE_I, {4{SYNC_EN_I}} & asgn_reg[6:3],
            SYNC_EN_I, {2{SYNC_EN_I}} & asgn_reg[1:0]};
    sval = {ASYNC_TXD_I, SYNC_PCS_I, SYNC_SCK_I, SYNC_MOSI_I, SYNC_MISO_I};
    sdrv = {1'b1, {3{SYNC_MASTER_I}},
            SYNC_MASTER_I && dir_reg[smpac_pkg::P_CS0],
            SYNC_MASTER_I,
            SYNC_MASTER_I,
            !SYNC_MASTER_I};
    drv  = (ser & sdrv) | (~ser & dir_reg);
    val  = (ser & sval) | (~ser & pdata_reg);
    od   = {ASYNC_OPEN_DRAIN_I, {7{SYNC_OPEN_DRAIN_I}}};
  end

  // Open-drain drives only low; the high level comes from the pull-up
  always_ff @(posedge CLK_I)
  begin
    if (!RSTN_I)
    begin
      PIN_O    <= 8'h00;
      PIN_OE_O <= 8'h00;
    end
    else
    begin
      PIN_O    <= val;
      PIN_OE_O <= drv & (~od | ~val);
    end
  end

  // ==========================================================
  // Inputs handed to the queued port
  assign ss_act = !pin_s2_reg[smpac_pkg::P_CS0];

  always_ff @(posedge CLK_I)
  begin
    if (!RSTN_I)
    begin
      SYNC_DIN_O        <= 1'b0;
      SYNC_SCK_O        <= 1'b0;
      SYNC_SEL_O        <= 1'b0;
      SYNC_MODE_FAULT_O <= 1'b0;
    end
    else
    begin
      SYNC_DIN_O <= SYNC_MASTER_I ? pin_s2_reg[smpac_pkg::P_MISO]
                                  : pin_s2_reg[smpac_pkg::P_MOSI];
      SYNC_SCK_O <= !SYNC_MASTER_I && pin_s2_reg[smpac_pkg::P_SCK];
      SYNC_SEL_O <= SYNC_EN_I && !SYNC_MASTER_I && ss_act;
      SYNC_MODE_FAULT_O <= SYNC_EN_I && SYNC_MASTER_I
                           && !dir_reg[smpac_pkg::P_CS0] && ss_act;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);

  sequence s_user_req;
    ACC_REQ_I && !ACC_SUPER_I;
  endsequence

  sequence s_denied_answer;
    ACC_ACK_O && ACC_DENY_O && (ACC_RDATA_O == 32'h0);
  endsequence

  a_global_user_deny: assert property (
    s_user_req and (ACC_ADDR_I < smpac_pkg::GLOBAL_END) |=> s_denied_answer)
    else $error("user access to global space not refused");

  a_restrict_user_deny: assert property (
    s_user_req and supervisor_restrict_bit_reg |=> s_denied_answer)
    else $error("restricted space open to user");

  a_open_user_ok: assert property (
    s_user_req and (!supervisor_restrict_bit_reg && ACC_ADDR_I >= smpac_pkg::GLOBAL_END) |=> !ACC_DENY_O)
    else $error("unrestricted user access refused");

  a_denied_write_void: assert property (
    ACC_REQ_I && ACC_WR_I && !permit
      |=> $stable(supervisor_restrict_bit_reg) && $stable(dir_reg) && $stable(pdata_reg))
    else $error("denied write changed state");

  a_restrict_clear: assert property (
    $fell(supervisor_restrict_bit_reg) |-> $past(ACC_SUPER_I) && $past(ACC_REQ_I))
    else $error("restrict bit cleared without supervisor");

  a_long_ram_read: assert property (
    ACC_REQ_I && !ACC_WR_I && permit && ACC_SIZE_I == smpac_pkg::SZ_LONG
      && ACC_ADDR_I == smpac_pkg::RAM_OFS
      |=> ACC_RDATA_O == {$past(ram_reg[0]), $past(ram_reg[1]),
                          $past(ram_reg[2]), $past(ram_reg[3])})
    else $error("long read of RAM wrong");

  a_rxd_dedicated: assert property (
    1'b1
      |-> ##2 (ASYNC_RXD_O == $past(PIN_RXD_I, 2)))
    else $error("receive pin not passed through");

  a_txd_async_drive: assert property (
    ASYNC_TX_ENABLE_I && !ASYNC_OPEN_DRAIN_I
      |=> PIN_OE_O[7] && PIN_O[7] == $past(ASYNC_TXD_I))
    else $error("transmit pin not given to async port");

  a_sync_od_low: assert property (
    SYNC_OPEN_DRAIN_I |=> (PIN_OE_O[6:0] & PIN_O[6:0]) == 7'h00)
    else $error("open-drain sync pin driven high");

  a_sck_master: assert property (
    SYNC_EN_I && SYNC_MASTER_I && !SYNC_OPEN_DRAIN_I |=> PIN_OE_O[2])
    else $error("master clock pin not driven");

  a_miso_slave: assert property (
    SYNC_EN_I && asgn_reg[0] && !SYNC_MASTER_I && !SYNC_OPEN_DRAIN_I
      |=> PIN_OE_O[0] && PIN_O[0] == $past(SYNC_MISO_I))
    else $error("slave data out not driven");
endmodule
`default_nettype wire

// ### rtl/smpac_pkg.sv
// Constants and types of the serial module pin and access glue
package smpac_pkg;
  // ==========================================================
  // Processor access map (byte addresses)
  localparam int unsigned ADDR_W     = 9;
  localparam logic [8:0]  GLOBAL_END = 9'h008;
  localparam logic [8:0]  CFG_OFS    = 9'h000;
  localparam logic [8:0]  PDATA_OFS  = 9'h014;
  localparam logic [8:0]  PASGN_OFS  = 9'h016;
  localparam logic [8:0]  RAM_OFS    = 9'h100;
  localparam int unsigned RAM_BYTES  = 80;
  // ==========================================================
  // Field positions and reset values
  localparam int unsigned SUPERVISOR_RESTRICT_BIT_POS   = 7;
  localparam logic        SUPERVISOR_RESTRICT_BIT_RST   = 1'b1;
  localparam logic [7:0]  PIN_RST    = 8'h00;
  localparam logic [7:0]  ASGN_MASK  = 8'h7b;
  // ==========================================================
  // Pin indices
  localparam int unsigned P_MISO = 0;
  localparam int unsigned P_MOSI = 1;
  localparam int unsigned P_SCK  = 2;
  localparam int unsigned P_CS0  = 3;
  localparam int unsigned P_TXD  = 7;
  // ==========================================================
  // Queue RAM regions
  localparam logic [6:0] RX_BASE  = 7'h00;
  localparam logic [6:0] TX_BASE  = 7'h20;
  localparam logic [6:0] CMD_BASE = 7'h40;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'b00,
    SZ_WORD = 2'b01,
    SZ_LONG = 2'b10
  } smpac_size_t;

  typedef enum logic [1:0] {
    RG_RX  = 2'b00,
    RG_TX  = 2'b01,
    RG_CMD = 2'b10
  } smpac_region_t;
endpackage

// ### tb/smpac_pin_model.sv
// Far-side model of the external pins and the receive line
`timescale 1ns/1ps
`default_nettype none
module smpac_pin_model (
  input  wire logic [7:0] pin_o_i,
  input  wire logic [7:0] pin_oe_i,
  input  wire logic [7:0] ext_val_i,
  input  wire logic [7:0] ext_oe_i,
  input  wire logic       rxd_val_i,
  output logic [7:0]      pin_lvl_o,
  output logic            rxd_o
);
  // ==========================================================
  // Wire resolution
  // Released lines go to the pull-up, so open-drain highs read as one
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      pin_lvl_o[i] = pin_oe_i[i] ? pin_o_i[i] : (ext_oe_i[i] ? ext_val_i[i] : 1'h1);
    end
  end
  assign rxd_o = rxd_val_i;
endmodule
`default_nettype wire

// ### tb/smpac_glue_tb_top.sv
// Self-checking bench of the serial module pin and access glue
`timescale 1ns/1ps
`default_nettype none
module smpac_glue_tb_top;
  localparam logic [1:0] SZB = smpac_pkg::SZ_BYTE;
  localparam logic [1:0] SZW = smpac_pkg::SZ_WORD;
  localparam logic [1:0] SZL = smpac_pkg::SZ_LONG;
  logic        clk = 1'h0;
  logic        rstn, req, wr, sup, s_en, s_mst, s_od, s_miso, s_mosi, s_sck;
  logic        q_req, q_wr, a_te, a_od, a_txd, rxd_v, rxd_p, ack, deny, supervisor_restrict_bit;
  logic        din, sck_o, sel, mf, rxd_o;
  logic [1:0]  size, q_rg;
  logic [3:0]  s_pcs;
  logic [4:0]  q_idx;
  logic [7:0]  q_wd, q_rd, pin_i, pin_o, pin_oe, ev, eo, p;
  logic [8:0]  addr;
  logic [31:0] wdata, rdata, r;
  logic [32:0] expq[$];
  int          err_count = 0;
  int          checks = 0;

  smpac_glue uut (
    .CLK_I(clk), .RSTN_I(rstn), .ACC_REQ_I(req), .ACC_WR_I(wr), .ACC_SUPER_I(sup),
    .ACC_SIZE_I(size), .ACC_ADDR_I(addr), .ACC_WDATA_I(wdata), .ACC_ACK_O(ack),
    .ACC_DENY_O(deny), .ACC_RDATA_O(rdata), .SUPERVISOR_RESTRICT_BIT_O(supervisor_restrict_bit), .SYNC_EN_I(s_en),
    .SYNC_MASTER_I(s_mst), .SYNC_OPEN_DRAIN_I(s_od), .SYNC_MISO_I(s_miso),
    .SYNC_MOSI_I(s_mosi), .SYNC_SCK_I(s_sck), .SYNC_PCS_I(s_pcs), .SYNC_DIN_O(din),
    .SYNC_SCK_O(sck_o), .SYNC_SEL_O(sel), .SYNC_MODE_FAULT_O(mf),
    .SYNC_RAM_REQ_I(q_req), .SYNC_RAM_WR_I(q_wr), .SYNC_RAM_REGION_I(q_rg),
    .SYNC_RAM_IDX_I(q_idx), .SYNC_RAM_WDATA_I(q_wd), .SYNC_RAM_RDATA_O(q_rd),
    .ASYNC_TX_ENABLE_I(a_te), .ASYNC_OPEN_DRAIN_I(a_od), .ASYNC_TXD_I(a_txd),
    .ASYNC_RXD_O(rxd_o), .PIN_RXD_I(rxd_p), .PIN_I(pin_i), .PIN_O(pin_o),
    .PIN_OE_O(pin_oe)
  );
  smpac_pin_model far (
    .pin_o_i(pin_o), .pin_oe_i(pin_oe), .ext_val_i(ev), .ext_oe_i(eo),
    .rxd_val_i(rxd_v), .pin_lvl_o(pin_i), .rxd_o(rxd_p)
  );

  always #4 clk = ~clk;

  // ==========================================================
  // Checking
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_acc(input logic [32:0] got, input logic [32:0] exp);
    cmp({31'h0, got[32]}, {31'h0, exp[32]});
    cmp(got[31:0], exp[31:0]);
  endtask

  always @(negedge clk)
  begin
    if (ack === 1'h1)
    begin
      if (expq.size() == 0)
      begin
        err_count++;
        $display("mismatch at %0t: answer without request", $time);
      end
      else
      begin
        cmp_acc({deny, rdata}, expq.pop_front());
      end
    end
  end

  task automatic end_sim;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
    begin
      $display("Simulation passed");
    end
    else
    begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Drivers
  // Two-cycle spacing so a request line is never driven twice in one step
  task automatic acc(input logic w, input logic s, input logic [1:0] z, input logic [8:0] a,
                     input logic [31:0] d, input logic [32:0] e);
    @(negedge clk);
    {req, wr, sup, size, addr, wdata} = {1'h1, w, s, z, a, d};
    expq.push_back(e);
    @(negedge clk);
    req = 1'h0;
  endtask

  task automatic qacc(input logic w, input logic [1:0] g, input logic [4:0] i,
                      input logic [7:0] d);
    @(negedge clk);
    {q_req, q_wr, q_rg, q_idx, q_wd} = {1'h1, w, g, i, d};
    @(negedge clk);
    q_req = 1'h0;
  endtask

  task automatic cfg(input logic [7:0] pd, input logic [7:0] as, input logic [7:0] dr);
    acc(1'h1, 1'h1, SZL, 9'h014, {8'h00, pd, as, dr}, 33'h0);
  endtask

  // Synchroniser paths need up to three cycles
  task automatic settle;
    repeat (4) @(negedge clk);
  endtask

  initial
  begin
    repeat (5000) @(negedge clk);
    err_count++;
    $display("mismatch at %0t: run did not finish", $time);
    end_sim;
  end

  // ==========================================================
  // Scenarios
  initial
  begin
    {rstn, req, wr, sup, size, addr, wdata, s_en, s_mst, s_od, s_miso, s_mosi} = '0;
    {s_sck, s_pcs, q_req, q_wr, q_rg, q_idx, q_wd, a_te, a_od, a_txd, rxd_v, ev, eo} = '0;
    void'($urandom(82));
    repeat (10) @(negedge clk);
    rstn = 1'h1;
    r = $urandom;
    cmp(supervisor_restrict_bit, 32'h1);
    acc(1'h0, 1'h0, SZB, 9'h001, 32'h0, {1'h1, 32'h0});
    acc(1'h0, 1'h1, SZB, 9'h001, 32'h0, {1'h0, 32'h80});
    acc(1'h1, 1'h0, SZB, 9'h001, 32'h0, {1'h1, 32'h0});
    acc(1'h1, 1'h0, SZL, 9'h100, r, {1'h1, 32'h0});
    acc(1'h0, 1'h0, SZL, 9'h100, 32'h0, {1'h1, 32'h0});
    acc(1'h0, 1'h1, SZL, 9'h100, 32'h0, 33'h0);
    cmp(supervisor_restrict_bit, 32'h1);
    acc(1'h1, 1'h1, SZB, 9'h001, 32'h0, 33'h0);
    cmp(supervisor_restrict_bit, 32'h0);
    acc(1'h0, 1'h0, SZB, 9'h001, 32'h0, {1'h1, 32'h0});
    acc(1'h1, 1'h0, SZL, 9'h100, r, 33'h0);
    acc(1'h0, 1'h0, SZL, 9'h100, 32'h0, {1'h0, r});
    acc(1'h0, 1'h0, SZW, 9'h102, 32'h0, {17'h0, r[15:0]});
    acc(1'h1, 1'h0, SZB, 9'h14f, r, 33'h0);
    acc(1'h0, 1'h0, SZB, 9'h14f, 32'h0, {25'h0, r[7:0]});
    acc(1'h0, 1'h0, SZB, 9'h150, 32'h0, 33'h0);
    qacc(1'h1, 2'h1, 5'h03, r[15:8]);
    acc(1'h0, 1'h0, SZB, 9'h123, 32'h0, {25'h0, r[15:8]});
    acc(1'h1, 1'h0, SZB, 9'h145, r >> 16, 33'h0);
    qacc(1'h0, 2'h2, 5'h05, 8'h00);
    @(negedge clk);
    cmp(q_rd, r[23:16]);
    qacc(1'h1, 2'h0, 5'h01, ~r[23:16]);
    acc(1'h0, 1'h0, SZB, 9'h101, 32'h0, {25'h0, ~r[23:16]});
    p = 8'($urandom);
    {s_miso, s_mosi, s_sck, s_pcs} = 7'($urandom);
    cfg(p, 8'h00, 8'hff);
    settle;
    cmp(pin_oe, 32'hff);
    cmp(pin_o, p);
    s_mst = 1'h1;
    s_en = 1'h1;
    settle;
    cmp(pin_o, {p[7:3], s_sck, p[1:0]});
    cfg(p, 8'hff, 8'h08);
    acc(1'h0, 1'h1, SZW, 9'h016, 32'h0, {17'h0, 8'h7b, 8'h08});
    ev = 8'($urandom);
    eo = 8'h01;
    settle;
    cmp(pin_oe, 32'h7e);
    cmp(pin_o & 8'h7e, {1'h0, s_pcs, s_sck, s_mosi, 1'h0});
    cmp(din, ev[0]);
    cmp(mf, 32'h0);
    s_od = 1'h1;
    settle;
    cmp(pin_oe & 8'h7e, {1'h0, ~s_pcs, ~s_sck, ~s_mosi, 1'h0});
    cfg(p, 8'hff, 8'h00);
    ev[3] = 1'h0;
    eo = 8'h09;
    settle;
    cmp(mf, 32'h1);
    s_en = 1'h0;
    @(negedge clk);
    s_od = 1'h0;
    s_mst = 1'h0;
    @(negedge clk);
    s_en = 1'h1;
    eo = 8'h0e;
    settle;
    cmp(pin_oe & 8'h0f, 32'h1);
    cmp(pin_o[0], s_miso);
    cmp(din, ev[1]);
    cmp(sck_o, ev[2]);
    cmp(sel, 32'h1);
    ev[3] = 1'h1;
    settle;
    cmp(sel, 32'h0);
    s_en = 1'h0;
    cfg(8'h80, 8'h00, 8'h80);
    settle;
    cmp({pin_oe[7], pin_o[7]}, 32'h3);
    cfg(8'h80, 8'h00, 8'h00);
    a_te = 1'h1;
    settle;
    cmp({pin_oe[7], pin_o[7]}, 32'h2);
    {a_od, a_txd} = 2'h3;
    settle;
    cmp(pin_oe[7], 32'h0);
    cmp(rxd_o, 32'h0);
    rxd_v = 1'h1;
    settle;
    cmp(rxd_o, 32'h1);
    for (int i = 0; i < 20 && expq.size() != 0; i++) @(negedge clk);
    if (expq.size() != 0)
    begin
      err_count++;
      $display("mismatch at %0t: answers missing", $time);
    end
    end_sim;
  end
endmodule
`default_nettype wire
